//--- src/perf_event_select.sv
// The AHB-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "perf_sel_params.svh"
module perf_event_select #(
  parameter int CW = 3,
  parameter int CNT_W = 48
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic fetchStallCycles,
  input wire logic codeCacheMissCount,
  input wire logic codeXlatWalkStart,
  input wire logic codeXlatWalkDone,
  input wire logic codeXlatWalkCycles,
  input wire logic codeXlatSecondLevelHit,
  input wire logic lengthPrefixStall,
  input wire logic instQueueFullStall,
  input wire logic branchValid,
  input wire perf_sel_pkg::branchKind_t branchKind,
  input wire logic branchTaken,
  input wire logic branchMispredict,
  input wire logic [CW-1:0] undeliveredOpSlots,
  input wire logic [5:0] portDispatch,
  input wire logic allocStallAny,
  input wire logic stationFullStall,
  input wire logic storeBufFullStall,
  output logic counterIncr
);
  import perf_sel_pkg::*;

  sel_if #(.CW(CW)) sel ();

  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic [CW-1:0] lastRaw_q;
  logic [CW-1:0] lastRaw_d;
  logic lastInc_q;
  logic lastInc_d;
  busState_t bus_q;
  busState_t bus_d;
  logic [7:0] addr_q;
  logic [7:0] addr_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [CNT_W-1:0] step;
  logic [7:0] cmask;
  logic accept;
  logic thresholdHit;

  function automatic logic [31:0] readMux(input logic [7:0] a, input logic [31:0] ctrl,
                                          input logic [CNT_W-1:0] cnt,
                                          input logic [CW-1:0] raw, input logic inc);
    logic [31:0] r;
    r = 32'h00000000;
    case (a)
      `OFF_CTRL: r = ctrl;
      `OFF_COUNT_LO: r = cnt[31:0];
      `OFF_COUNT_HI: r = 32'(cnt[CNT_W-1:32]);
      `OFF_STATUS: begin
        r[CW-1:0] = raw;
        r[`STATUS_INC_BIT] = inc;
      end
      default: r = 32'h00000000;
    endcase
    return r;
  endfunction

  assign sel.eventNum = ctrl_q[`CTRL_EVENT_LSB +: 8];
  assign sel.unitMask = ctrl_q[`CTRL_UMASK_LSB +: 8];
  assign cmask = ctrl_q[`CTRL_CMASK_LSB +: 8];

  perf_event_decode #(.CW(CW)) decode (
    .sel(sel.decoder),
    .fetchStallCycles(fetchStallCycles),
    .codeCacheMissCount(codeCacheMissCount),
    .codeXlatWalkStart(codeXlatWalkStart),
    .codeXlatWalkDone(codeXlatWalkDone),
    .codeXlatWalkCycles(codeXlatWalkCycles),
    .codeXlatSecondLevelHit(codeXlatSecondLevelHit),
    .lengthPrefixStall(lengthPrefixStall),
    .instQueueFullStall(instQueueFullStall),
    .branchValid(branchValid),
    .branchKind(branchKind),
    .branchTaken(branchTaken),
    .branchMispredict(branchMispredict),
    .undeliveredOpSlots(undeliveredOpSlots),
    .portDispatch(portDispatch),
    .allocStallAny(allocStallAny),
    .stationFullStall(stationFullStall),
    .storeBufFullStall(storeBufFullStall)
  );

  // threshold stage: raw count, or one per cycle once the threshold is met
  always_comb begin
    thresholdHit = ({{(8-CW){1'b0}}, sel.rawCount} >= cmask);
    if (cmask == 8'h00) begin
      step = CNT_W'(sel.rawCount);
    end else begin
      step = CNT_W'(thresholdHit ^ ctrl_q[`CTRL_INVERT_BIT]);
    end
    if (!ctrl_q[`CTRL_ENABLE_BIT]) begin
      step = '0;
    end
  end

  // reads take one wait state so a write just finished is always seen
  assign accept = hsel & hready & htrans[1];
  assign hreadyout = (bus_q != BUS_RDWAIT);
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  always_comb begin
    bus_d = bus_q;
    addr_d = addr_q;
    rdata_d = rdata_q;
    ctrl_d = ctrl_q;
    count_d = count_q + step;
    lastRaw_d = sel.rawCount;
    lastInc_d = (step != '0);
    if (bus_q == BUS_WRITE) begin
      // a software load of one counter half wins over this cycle's increment to that half; the other half still takes it
      case (addr_q)
        `OFF_CTRL: ctrl_d = hwdata & `CTRL_WMASK;
        `OFF_COUNT_LO: count_d[31:0] = hwdata;
        `OFF_COUNT_HI: count_d[CNT_W-1:32] = hwdata[CNT_W-33:0];
        default: ctrl_d = ctrl_q;
      endcase
    end
    if (bus_q == BUS_RDWAIT) begin
      rdata_d = readMux(addr_q, ctrl_q, count_q, lastRaw_q, lastInc_q);
      bus_d = BUS_RDDATA;
    end else if (accept) begin
      addr_d = {haddr[7:2], 2'b00};
      bus_d = hwrite ? BUS_WRITE : BUS_RDWAIT;
    end else begin
      bus_d = BUS_IDLE;
    end
  end

  // clkEn low freezes bus and counter alike
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bus_q <= BUS_IDLE;
      addr_q <= 8'h00;
      rdata_q <= 32'h00000000;
      ctrl_q <= `CTRL_RESET;
      count_q <= '0;
      lastRaw_q <= '0;
      lastInc_q <= 1'b0;
    end else if (clkEn) begin
      bus_q <= bus_d;
      addr_q <= addr_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
      count_q <= count_d;
      lastRaw_q <= lastRaw_d;
      lastInc_q <= lastInc_d;
    end
  end

  assign counterIncr = lastInc_q;

  // hsize is not decoded: only whole-word transfers are supported
  logic unusedSize;
  assign unusedSize = ^hsize;
endmodule
`default_nettype wire

//--- src/perf_sel_params.svh
// What this block does
// - event 80H mask 04H counts cycles code fetch stalls on cache or translation miss
// - event 80H mask 02H counts code cache, stream and victim misses, uncacheable too
// - event 85H counts walk start 01H, walk done 02H, walker busy 04H, second hit 10H
// - event 87H counts length prefix stalls 01H and queue full stall cycles 04H
// - event 88H type bits 01H..20H pick cond, jump, indirect, return, call, indirect call
// - bit 40H picks not-taken, only for conditional; bit 80H picks taken
// - event 88H mask FFH counts every executed near branch, squashed ones too
// - event 89H applies the same qualification to mispredicted branches, no jump bit
// - event 9CH mask 01H counts undelivered op slots; threshold may qualify bandwidth
// - event A1H counts dispatch cycles per port, each port with its own mask
// - event A2H counts allocation stalls: any 01H, station full 04H, store buffer 08H
// - nonzero threshold makes one increment per cycle the count reaches it
// - invert with threshold counts cycles below the threshold
`ifndef PERF_SEL_PARAMS_SVH
`define PERF_SEL_PARAMS_SVH

`define EV_FETCH 8'h80
`define EV_CODE_XLAT 8'h85
`define EV_DECODE_STALL 8'h87
`define EV_BRANCH_EXEC 8'h88
`define EV_BRANCH_MISP 8'h89
`define EV_UNDELIVERED 8'h9c
`define EV_PORT_DISPATCH 8'ha1
`define EV_ALLOC_STALL 8'ha2

`define UM_FETCH_STALL 8'h04
`define UM_CODE_MISS 8'h02
`define UM_WALK_START 8'h01
`define UM_WALK_DONE 8'h02
`define UM_WALK_CYCLES 8'h04
`define UM_SECOND_HIT 8'h10
`define UM_LENGTH_PREFIX 8'h01
`define UM_QUEUE_FULL 8'h04
`define UM_UNDELIVERED 8'h01
`define UM_PORT0 8'h01
`define UM_PORT1 8'h02
`define UM_PORT2 8'h0c
`define UM_PORT3 8'h30
`define UM_PORT4 8'h40
`define UM_PORT5 8'h80
`define UM_ALLOC_ANY 8'h01
`define UM_ALLOC_STATION 8'h04
`define UM_ALLOC_STORE_BUF 8'h08
`define UM_BR_ALL 8'hff

`define BR_COND_BIT 0
`define BR_DIRECT_JMP_BIT 1
`define BR_INDIRECT_JMP_BIT 2
`define BR_RETURN_BIT 3
`define BR_DIRECT_CALL_BIT 4
`define BR_INDIRECT_CALL_BIT 5
`define BR_NOT_TAKEN_BIT 6
`define BR_TAKEN_BIT 7

`define OFF_CTRL 8'h00
`define OFF_COUNT_LO 8'h04
`define OFF_COUNT_HI 8'h08
`define OFF_STATUS 8'h0c

`define CTRL_EVENT_LSB 0
`define CTRL_UMASK_LSB 8
`define CTRL_ENABLE_BIT 16
`define CTRL_INVERT_BIT 23
`define CTRL_CMASK_LSB 24
`define CTRL_WMASK 32'hff81ffff
`define CTRL_RESET 32'h00000000
`define STATUS_INC_BIT 8

`endif

//--- src/perf_sel_pkg.sv
package perf_sel_pkg;

  typedef enum logic [2:0] {
    BR_COND = 3'b000,
    BR_DIRECT_JMP = 3'b001,
    BR_INDIRECT_JMP = 3'b010,
    BR_RETURN = 3'b011,
    BR_DIRECT_CALL = 3'b100,
    BR_INDIRECT_CALL = 3'b101
  } branchKind_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_RDWAIT = 2'b10,
    BUS_RDDATA = 2'b11
  } busState_t;

endpackage

//--- src/sel_if.sv
`timescale 1ns/1ns
`default_nettype none
interface sel_if #(parameter int CW = 3);
  logic [7:0] eventNum;
  logic [7:0] unitMask;
  logic [CW-1:0] rawCount;
  modport owner (output eventNum, output unitMask, input rawCount);
  modport decoder (input eventNum, input unitMask, output rawCount);
endinterface
`default_nettype wire

//--- src/perf_event_decode.sv
`timescale 1ns/1ns
`default_nettype none
`include "perf_sel_params.svh"
module perf_event_decode #(
  parameter int CW = 3
) (
  sel_if.decoder sel,
  input wire logic fetchStallCycles,
  input wire logic codeCacheMissCount,
  input wire logic codeXlatWalkStart,
  input wire logic codeXlatWalkDone,
  input wire logic codeXlatWalkCycles,
  input wire logic codeXlatSecondLevelHit,
  input wire logic lengthPrefixStall,
  input wire logic instQueueFullStall,
  input wire logic branchValid,
  input wire perf_sel_pkg::branchKind_t branchKind,
  input wire logic branchTaken,
  input wire logic branchMispredict,
  input wire logic [CW-1:0] undeliveredOpSlots,
  input wire logic [5:0] portDispatch,
  input wire logic allocStallAny,
  input wire logic stationFullStall,
  input wire logic storeBufFullStall
);
  import perf_sel_pkg::*;

  function automatic logic [CW-1:0] one(input logic b);
    return {{(CW-1){1'b0}}, b};
  endfunction

  // shared by executed and mispredicted branches; the direct jump bit works only for executed
  function automatic logic brQualify(input logic [7:0] um, input logic allowJmp,
                                     input logic valid, input branchKind_t kind,
                                     input logic taken);
    logic typeHit;
    logic dirHit;
    typeHit = 1'b0;
    if (um == `UM_BR_ALL) begin
      return valid;
    end
    case (kind)
      BR_COND: typeHit = um[`BR_COND_BIT];
      BR_DIRECT_JMP: typeHit = um[`BR_DIRECT_JMP_BIT] & allowJmp;
      BR_INDIRECT_JMP: typeHit = um[`BR_INDIRECT_JMP_BIT];
      BR_RETURN: typeHit = um[`BR_RETURN_BIT];
      BR_DIRECT_CALL: typeHit = um[`BR_DIRECT_CALL_BIT];
      BR_INDIRECT_CALL: typeHit = um[`BR_INDIRECT_CALL_BIT];
      default: typeHit = 1'b0;
    endcase
    // a type without a direction bit never counts
    dirHit = (taken & um[`BR_TAKEN_BIT])
           | (!taken & um[`BR_NOT_TAKEN_BIT] & (kind == BR_COND));
    return valid & typeHit & dirHit;
  endfunction

  always_comb begin
    sel.rawCount = '0;
    case (sel.eventNum)
      `EV_FETCH: begin
        case (sel.unitMask)
          `UM_FETCH_STALL: sel.rawCount = one(fetchStallCycles);
          `UM_CODE_MISS: sel.rawCount = one(codeCacheMissCount);
          default: sel.rawCount = '0;
        endcase
      end
      `EV_CODE_XLAT: begin
        case (sel.unitMask)
          `UM_WALK_START: sel.rawCount = one(codeXlatWalkStart);
          `UM_WALK_DONE: sel.rawCount = one(codeXlatWalkDone);
          `UM_WALK_CYCLES: sel.rawCount = one(codeXlatWalkCycles);
          `UM_SECOND_HIT: sel.rawCount = one(codeXlatSecondLevelHit);
          default: sel.rawCount = '0;
        endcase
      end
      `EV_DECODE_STALL: begin
        case (sel.unitMask)
          `UM_LENGTH_PREFIX: sel.rawCount = one(lengthPrefixStall);
          `UM_QUEUE_FULL: sel.rawCount = one(instQueueFullStall);
          default: sel.rawCount = '0;
        endcase
      end
      `EV_BRANCH_EXEC: begin
        sel.rawCount = one(brQualify(sel.unitMask, 1'b1, branchValid, branchKind,
                                     branchTaken));
      end
      `EV_BRANCH_MISP: begin
        sel.rawCount = one(brQualify(sel.unitMask, 1'b0, branchValid & branchMispredict,
                                     branchKind, branchTaken));
      end
      `EV_UNDELIVERED: begin
        if (sel.unitMask == `UM_UNDELIVERED) begin
          sel.rawCount = undeliveredOpSlots;
        end
      end
      `EV_PORT_DISPATCH: begin
        case (sel.unitMask)
          `UM_PORT0: sel.rawCount = one(portDispatch[0]);
          `UM_PORT1: sel.rawCount = one(portDispatch[1]);
          `UM_PORT2: sel.rawCount = one(portDispatch[2]);
          `UM_PORT3: sel.rawCount = one(portDispatch[3]);
          `UM_PORT4: sel.rawCount = one(portDispatch[4]);
          `UM_PORT5: sel.rawCount = one(portDispatch[5]);
          default: sel.rawCount = '0;
        endcase
      end
      `EV_ALLOC_STALL: begin
        case (sel.unitMask)
          `UM_ALLOC_ANY: sel.rawCount = one(allocStallAny);
          `UM_ALLOC_STATION: sel.rawCount = one(stationFullStall);
          `UM_ALLOC_STORE_BUF: sel.rawCount = one(storeBufFullStall);
          default: sel.rawCount = '0;
        endcase
      end
      default: sel.rawCount = '0;
    endcase
  end
endmodule
`default_nettype wire

//--- tb/event_source.sv
`timescale 1ns/1ns
`default_nettype none
module event_source
  import perf_sel_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [25:0] stim,
  output logic fetchStallCycles,
  output logic codeCacheMissCount,
  output logic codeXlatWalkStart,
  output logic codeXlatWalkDone,
  output logic codeXlatWalkCycles,
  output logic codeXlatSecondLevelHit,
  output logic lengthPrefixStall,
  output logic instQueueFullStall,
  output logic allocStallAny,
  output logic stationFullStall,
  output logic storeBufFullStall,
  output logic branchValid,
  output var perf_sel_pkg::branchKind_t branchKind,
  output logic branchTaken,
  output logic branchMispredict,
  output logic [2:0] undeliveredOpSlots,
  output logic [5:0] portDispatch
);
  logic [25:0] events_q, events_d;
  logic [2:0] kindBits;
  // registered so every event level changes just after an edge, as the pipeline would
  always_comb begin
    events_d = stim;
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      events_q <= 26'h0;
    end else begin
      events_q <= events_d;
    end
  end
  assign {portDispatch, undeliveredOpSlots, branchMispredict, branchTaken, kindBits,
    branchValid, storeBufFullStall, stationFullStall, allocStallAny, instQueueFullStall,
    lengthPrefixStall, codeXlatSecondLevelHit, codeXlatWalkCycles, codeXlatWalkDone,
    codeXlatWalkStart, codeCacheMissCount, fetchStallCycles} = events_q;
  assign branchKind = branchKind_t'(kindBits);
endmodule
`default_nettype wire

//--- tb/perf_select_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module perf_select_monitor #(
  parameter int CW = 3
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic fetchStallCycles,
  input wire logic branchValid,
  input wire logic [CW-1:0] undeliveredOpSlots,
  input wire logic [5:0] portDispatch,
  input wire logic counterIncr
);
  logic wrPend_q, wrPend_d;
  logic [31:0] ctrl_q, ctrl_d;
  // shadow of the control word, kept from bus writes since only ports are visible
  always_comb begin
    wrPend_d = wrPend_q;
    ctrl_d = ctrl_q;
    if (hready) begin
      if (wrPend_q) begin
        ctrl_d = hwdata;
      end
      wrPend_d = hsel && htrans[1] && hwrite && (haddr[7:0] == 8'h00);
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wrPend_q <= 1'b0;
      ctrl_q <= 32'h0;
    end else begin
      wrPend_q <= wrPend_d;
      ctrl_q <= ctrl_d;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence rdTaken;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence rdAnswer;
    !hreadyout ##1 hreadyout;
  endsequence
  read_wait_a: assert property (rdTaken |=> rdAnswer) else $error("read wait state wrong");
  write_no_wait_a: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
    else $error("write stalled");
  disabled_quiet_a: assert property (!ctrl_q[16] |=> !counterIncr)
    else $error("step while disabled");
  fetch_stall_a: assert property (ctrl_q == 32'h00010480 |=>
    counterIncr == $past(fetchStallCycles)) else $error("fetch stall step wrong");
  branch_all_a: assert property (ctrl_q == 32'h0001ff88 |=>
    counterIncr == $past(branchValid)) else $error("all branch step wrong");
  undefined_quiet_a: assert property (ctrl_q == 32'h00010880 |=> !counterIncr)
    else $error("undefined event stepped");
  threshold_a: assert property (ctrl_q == 32'h0201019c |=>
    counterIncr == $past(undeliveredOpSlots >= 2)) else $error("threshold step wrong");
  invert_a: assert property (ctrl_q == 32'h0181019c |=>
    counterIncr == $past(undeliveredOpSlots == 0)) else $error("inverted step wrong");
  port_four_a: assert property (ctrl_q == 32'h000140a1 |=>
    counterIncr == $past(portDispatch[4])) else $error("port step wrong");
endmodule
bind perf_event_select perf_select_monitor #(.CW(CW)) u_perf_select_monitor (
  .clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .fetchStallCycles(fetchStallCycles), .branchValid(branchValid),
  .undeliveredOpSlots(undeliveredOpSlots), .portDispatch(portDispatch),
  .counterIncr(counterIncr));
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "perf_sel_params.svh"
module testbench;
  import perf_sel_pkg::*;
  typedef struct packed {
    logic [7:0] ev, um, cm;
    logic threshold_invert;
    logic [25:0] vec;
    logic [2:0] per;
  } row_t;
  logic clock = 1'b0, rst_b = 1'b0, clkEn = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdData;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [25:0] stim = 26'h0;
  logic hreadyout, hresp, counterIncr, fetchStallCycles, codeCacheMissCount;
  logic codeXlatWalkStart, codeXlatWalkDone, codeXlatWalkCycles, codeXlatSecondLevelHit;
  logic lengthPrefixStall, instQueueFullStall, allocStallAny, stationFullStall;
  logic storeBufFullStall, branchValid, branchTaken, branchMispredict;
  branchKind_t branchKind;
  logic [2:0] undeliveredOpSlots;
  logic [5:0] portDispatch;
  int errors = 0, checks = 0;
  logic [7:0] pm[6] = '{8'h01, 8'h02, 8'h0c, 8'h30, 8'h40, 8'h80};
  row_t rows[$] = '{
    '{8'h80, 8'h04, 8'h00, 1'b0, 26'h0000001, 3'd1},
    '{8'h80, 8'h02, 8'h00, 1'b0, 26'h0000002, 3'd1},
    '{8'h85, 8'h01, 8'h00, 1'b0, 26'h0000004, 3'd1},
    '{8'h85, 8'h02, 8'h00, 1'b0, 26'h0000008, 3'd1},
    '{8'h85, 8'h04, 8'h00, 1'b0, 26'h0000010, 3'd1},
    '{8'h85, 8'h10, 8'h00, 1'b0, 26'h0000020, 3'd1},
    '{8'h85, 8'h01, 8'h00, 1'b0, 26'h0000038, 3'd0},
    '{8'h87, 8'h01, 8'h00, 1'b0, 26'h0000040, 3'd1},
    '{8'h87, 8'h04, 8'h00, 1'b0, 26'h0000080, 3'd1},
    '{8'h88, 8'hc1, 8'h00, 1'b0, 26'h0000800, 3'd1},
    '{8'h88, 8'h81, 8'h00, 1'b0, 26'h0000800, 3'd0},
    '{8'h88, 8'h42, 8'h00, 1'b0, 26'h0001800, 3'd0},
    '{8'h88, 8'hff, 8'h00, 1'b0, 26'h0003800, 3'd1},
    '{8'h89, 8'h81, 8'h00, 1'b0, 26'h0018800, 3'd1},
    '{8'h89, 8'h81, 8'h00, 1'b0, 26'h0008800, 3'd0},
    '{8'h89, 8'hff, 8'h00, 1'b0, 26'h0013800, 3'd1},
    '{8'h9c, 8'h01, 8'h00, 1'b0, 26'h0060000, 3'd3},
    '{8'h9c, 8'h01, 8'h02, 1'b0, 26'h0060000, 3'd1},
    '{8'h9c, 8'h01, 8'h04, 1'b0, 26'h0060000, 3'd0},
    '{8'h9c, 8'h01, 8'h01, 1'b1, 26'h0000000, 3'd1},
    '{8'ha2, 8'h01, 8'h00, 1'b0, 26'h0000100, 3'd1},
    '{8'ha2, 8'h04, 8'h00, 1'b0, 26'h0000200, 3'd1},
    '{8'ha2, 8'h08, 8'h00, 1'b0, 26'h0000400, 3'd1},
    '{8'h88, 8'h89, 8'h00, 1'b0, 26'h000b800, 3'd1},
    '{8'h80, 8'h08, 8'h00, 1'b0, 26'h0000fff, 3'd0},
    '{8'h88, 8'h00, 8'h00, 1'b0, 26'h0008800, 3'd0}};
  assign hready = hreadyout;
  perf_event_select #(.CW(3)) u_perf_event_select (.*);
  event_source u_event_source (.*);
  initial forever #50 clock = ~clock;
  task automatic waitRdy;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    rdData = hrdata;
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    waitRdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // inverted rows idle at four slots so only the five active cycles can step
  task automatic run(input row_t r);
    stim <= r.threshold_invert ? 26'h0080000 : 26'h0;
    bus(1'b1, `OFF_COUNT_LO, 32'h0);
    bus(1'b1, `OFF_CTRL, {r.cm, r.threshold_invert, 6'h0, 1'b1, r.um, r.ev});
    stim <= r.vec;
    repeat (5) @(posedge clock);
    stim <= r.threshold_invert ? 26'h0080000 : 26'h0;
    bus(1'b1, `OFF_CTRL, 32'h0);
    bus(1'b0, `OFF_COUNT_LO, 32'h0);
    chk("count", 32'(r.per) * 32'h5, rdData);
    $display("test %h %h done", r.ev, r.um);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    errors++;
    summarize;
  end
  initial begin
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    foreach (rows[i]) run(rows[i]);
    for (int k = 0; k < 6; k++) begin
      run('{8'h88, 8'h80 | (8'h1 << k), 8'h0, 1'b0, 26'h8800 | (26'(k) << 12), 3'd1});
      run('{8'h88, 8'h80 | (8'h1 << ((k + 1) % 6)), 8'h0, 1'b0, 26'h8800 | (26'(k) << 12),
        3'd0});
      run('{8'ha1, pm[k], 8'h0, 1'b0, 26'h1 << (20 + k), 3'd1});
      run('{8'ha1, pm[k], 8'h0, 1'b0, 26'h3f00000 & ~(26'h1 << (20 + k)), 3'd0});
    end
    bus(1'b1, `OFF_CTRL, 32'hffffffff);
    bus(1'b0, `OFF_CTRL, 32'h0);
    chk("ctrl mask", `CTRL_WMASK, rdData);
    bus(1'b1, 8'h10, 32'hffffffff);
    bus(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h0, rdData);
    stim <= 26'h0060000;
    bus(1'b1, `OFF_CTRL, 32'h0001019c);
    bus(1'b1, `OFF_COUNT_LO, 32'h0);
    bus(1'b0, `OFF_STATUS, 32'h0);
    chk("status", 32'h00000103, rdData);
    chk("incr", 32'h1, {31'h0, counterIncr});
    clkEn <= 1'b0;
    repeat (20) @(posedge clock);
    clkEn <= 1'b1;
    bus(1'b1, `OFF_CTRL, 32'h0);
    bus(1'b0, `OFF_COUNT_LO, 32'h0);
    // seven enabled edges of three slots each; the twenty frozen edges add nothing
    chk("frozen count", 32'h00000015, rdData);
    $display("test freeze done");
    bus(1'b1, `OFF_COUNT_HI, 32'h1234abcd);
    bus(1'b0, `OFF_COUNT_HI, 32'h0);
    chk("count hi", 32'h0000abcd, rdData);
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    bus(1'b0, `OFF_CTRL, 32'h0);
    chk("ctrl reset", `CTRL_RESET, rdData);
    bus(1'b0, `OFF_COUNT_LO, 32'h0);
    chk("count reset", 32'h0, rdData);
    chk("okay", 32'h0, {31'h0, hresp});
    $display("test registers done");
    summarize;
  end
endmodule
`default_nettype wire
